// *** logic/btcx_pkg.sv ***
`default_nettype none
package btcx_pkg;

  // ----------------------------------------------------------------
  // machine cycle lengths in T-states, one T-state per clk
  // ----------------------------------------------------------------
  localparam logic [2:0] T_M1 = 3'h4;
  localparam logic [2:0] T_RD3 = 3'h3;
  localparam logic [2:0] T_RD4 = 3'h4;
  localparam logic [2:0] T_RD5 = 3'h5;
  localparam logic [2:0] T_WR3 = 3'h3;

  // ----------------------------------------------------------------
  // opcodes and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_CB = 8'hCB;
  localparam logic [7:0] OP_PFX_X = 8'hDD;
  localparam logic [7:0] OP_PFX_Y = 8'hFD;
  localparam logic [7:0] OP_CALL = 8'hCD;
  localparam logic [7:0] OP_CARRY_INV = 8'h3F;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_CALLCC = 2'h3;
  localparam logic [2:0] LOW_CALLCC = 3'h4;
  localparam int BS_LSB = 3;
  localparam int RF_LSB = 0;
  localparam int CC_LSB = 3;
  localparam int GRP_LSB = 6;

  // register codes; code 6 never names a register, so slot 6 holds the flags
  localparam logic [2:0] RG_B = 3'h0;
  localparam logic [2:0] RG_C = 3'h1;
  localparam logic [2:0] RG_D = 3'h2;
  localparam logic [2:0] RG_E = 3'h3;
  localparam logic [2:0] RG_H = 3'h4;
  localparam logic [2:0] RG_L = 3'h5;
  localparam logic [2:0] RG_MEM = 3'h6;
  localparam logic [2:0] RG_F = 3'h6;
  localparam logic [2:0] RG_A = 3'h7;

  localparam logic [2:0] CC_NOT_ZERO = 3'h0;
  localparam logic [2:0] CC_Z = 3'h1;
  localparam logic [2:0] CC_NC = 3'h2;
  localparam logic [2:0] CC_C = 3'h3;
  localparam logic [2:0] CC_PAR_ODD = 3'h4;
  localparam logic [2:0] CC_PAR_EVEN = 3'h5;
  localparam logic [2:0] CC_P = 3'h6;
  localparam logic [2:0] CC_M = 3'h7;

  localparam int FL_S = 7;
  localparam int FL_Z = 6;
  localparam int FL_H = 4;
  localparam int FL_PV = 2;
  localparam int FL_N = 1;
  localparam int FL_C = 0;

  localparam logic [1:0] PFX_NONE = 2'h0;
  localparam logic [1:0] PFX_X = 2'h1;
  localparam logic [1:0] PFX_Y = 2'h2;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_AF = 8'h08;
  localparam logic [7:0] ADR_BC = 8'h0C;
  localparam logic [7:0] ADR_DE = 8'h10;
  localparam logic [7:0] ADR_PTR = 8'h14;
  localparam logic [7:0] ADR_IDX_X = 8'h18;
  localparam logic [7:0] ADR_IDX_Y = 8'h1C;
  localparam logic [7:0] ADR_SP = 8'h20;
  localparam logic [7:0] ADR_PC = 8'h24;
  localparam int CTRL_RUN = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_UNSUP = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_IDLE = 4'h0, PH_FETCH = 4'h1, PH_CBOP = 4'h3, PH_MRD = 4'h2,
    PH_PFX = 4'h6, PH_DISP = 4'h7, PH_XOP = 4'h5, PH_NLO = 4'h4,
    PH_NHI = 4'hC, PH_PUSHH = 4'hD, PH_PUSHL = 4'hF
  } btcx_phase_t;

  typedef struct packed {
    logic m1;
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } btcx_mem_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } btcx_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } btcx_axi_rsp_t;

  typedef struct packed {
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_have;
    logic [7:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } btcx_axil_t;

endpackage
`default_nettype wire

// *** logic/btcx_axil.sv ***
`timescale 1ns/1ps
`default_nettype none
module btcx_axil (
  input wire logic clk,
  input wire logic rst,
  input wire btcx_pkg::btcx_axi_req_t axi_req,
  output var btcx_pkg::btcx_axi_rsp_t axi_rsp,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  import btcx_pkg::*;

  btcx_axil_t q, d;

  // address and data are caught in either order; the access runs once both are held
  always_comb begin
    d = q;
    axi_rsp.awready = !q.aw_have && !q.bvalid;
    axi_rsp.wready = !q.w_have && !q.bvalid;
    axi_rsp.arready = !q.ar_have && !q.rvalid;
    axi_rsp.bvalid = q.bvalid;
    axi_rsp.bresp = q.bresp;
    axi_rsp.rvalid = q.rvalid;
    axi_rsp.rdata = q.rdata;
    axi_rsp.rresp = q.rresp;
    wr_en = q.aw_have && q.w_have && !q.bvalid;
    wr_addr = q.awaddr;
    wr_data = q.wdata;
    wr_strb = q.wstrb;
    rd_en = q.ar_have && !q.rvalid;
    rd_addr = q.araddr;
    if (axi_req.awvalid && axi_rsp.awready) begin
      d.aw_have = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      d.w_have = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (wr_en) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (q.bvalid && axi_req.bready) begin
      d.bvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      d.ar_have = 1'b1;
      d.araddr = axi_req.araddr;
    end
    if (rd_en) begin
      d.ar_have = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = rd_data;
      d.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (q.rvalid && axi_req.rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// *** logic/btcx_core.sv ***
// Operation
// - bit test on byte at pointer pair: 3 machine cycles, 12 T-states (4,4,4).
// - every bit test loads zero flag with the inverse of the selected bit.
// - bit test sets half-carry, clears subtract, keeps carry; sign, parity undefined.
// - bit-select field is a binary index, 000 is bit 0, 111 is bit 7.
// - register field: B 000, C 001, D 010, E 011, H 100, L 101, A 111.
// - indexed address is index register plus sign-extended displacement; DD/FD then CB.
// - indexed bit test: 5 machine cycles, 20 T-states (4,4,3,5,4).
// - register bit test: 2 machine cycles, 8 T-states (4,4).
// - bit test leaves the tested operand unchanged; only flags change.
// - conditional call pushes and jumps when true, else continues sequentially.
// - push: decrement stack pointer, write high byte, decrement, write low byte.
// - pushed return address is the counter past the three-byte call.
// - call target comes from the two operand bytes, low byte first.
// - condition 000..111: zero clr/set, carry clr/set, parity odd/even, sign clr/set.
// - false conditional call: 3 machine cycles, 10 T-states (4,3,3).
// - true or unconditional call: 5 machine cycles, 17 T-states (4,3,4,3,3).
// - calls leave every condition flag unchanged.
// - unconditional call always pushes the return address, then jumps.
// - carry invert replaces the carry flag with its complement.
// - carry invert copies old carry to half-carry, clears subtract, 4 T-states.
// - memory bit test reads at the pointer pair without changing it.
`timescale 1ns/1ps
`default_nettype none
module btcx_core (
  input wire logic clk,
  input wire logic rst,
  input wire btcx_pkg::btcx_axi_req_t axi_req,
  output var btcx_pkg::btcx_axi_rsp_t axi_rsp,
  output var btcx_pkg::btcx_mem_t mem_o,
  input wire logic [7:0] mem_rdata
);
  import btcx_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    btcx_phase_t phase;
    logic [2:0] tcnt;
    logic [7:0] op;
    logic [1:0] pfx;
    logic take;
    logic [15:0] ea;
    logic [7:0] lo;
    logic [7:0][7:0] gr;
    logic [15:0] idx_x;
    logic [15:0] idx_y;
    logic [15:0] sp;
    logic [15:0] pc;
    logic run;
    logic unsup;
    btcx_mem_t mem;
  } btcx_core_t;

  btcx_core_t s_q, s_d;
  logic wr_en, rd_en, wr_err, rd_err, fin;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  btcx_axil u_axil (
    .clk(clk),
    .rst(rst),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign mem_o = s_q.mem;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] put16(logic [15:0] old, logic [31:0] v, logic [3:0] st);
    return {st[1] ? v[15:8] : old[15:8], st[0] ? v[7:0] : old[7:0]};
  endfunction

  // memory request is held for the whole machine cycle, read data taken at its last T-state
  function automatic btcx_core_t enter(btcx_core_t s, btcx_phase_t p, logic [2:0] len,
                                       logic [15:0] ad, logic wr, logic [7:0] wd);
    s.phase = p;
    s.tcnt = len - 3'h1;
    s.mem.m1 = (p == PH_FETCH);
    s.mem.rd = !wr;
    s.mem.wr = wr;
    s.mem.addr = ad;
    s.mem.wdata = wd;
    return s;
  endfunction

  function automatic btcx_core_t next_instr(btcx_core_t s);
    s.pfx = PFX_NONE;
    if (s.run) begin
      s = enter(s, PH_FETCH, T_M1, s.pc, 1'b0, 8'h00);
    end else begin
      s.phase = PH_IDLE;
      s.tcnt = 3'h0;
      s.mem = '0;
    end
    return s;
  endfunction

  // sign and parity are left as they were, which is one legal reading of undefined
  function automatic btcx_core_t bit_test(btcx_core_t s, logic [7:0] v);
    s.gr[RG_F][FL_Z] = ~v[s.op[BS_LSB +: 3]];
    s.gr[RG_F][FL_H] = 1'b1;
    s.gr[RG_F][FL_N] = 1'b0;
    return s;
  endfunction

  function automatic logic cond_ok(logic [2:0] cc, logic [7:0] f);
    logic r;
    r = 1'b0;
    unique case (cc)
      CC_NOT_ZERO: r = !f[FL_Z];
      CC_Z: r = f[FL_Z];
      CC_NC: r = !f[FL_C];
      CC_C: r = f[FL_C];
      CC_PAR_ODD: r = !f[FL_PV];
      CC_PAR_EVEN: r = f[FL_PV];
      CC_P: r = !f[FL_S];
      CC_M: r = f[FL_S];
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // sequencer and register file
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] idx;
    logic [15:0] pc1;
    logic [15:0] sp1;
    idx = 16'h0000;
    pc1 = s_q.pc + 16'h1;
    sp1 = s_q.sp - 16'h1;
    s_d = s_q;
    fin = 1'b0;
    rd_err = 1'b0;
    wr_err = 1'b0;
    rd_data = 32'h00000000;
    unique case (rd_addr)
      ADR_CTRL: rd_data = 32'(s_q.run);
      ADR_STATUS: rd_data = 32'({s_q.unsup, s_q.phase != PH_IDLE});
      ADR_AF: rd_data = 32'({s_q.gr[RG_A], s_q.gr[RG_F]});
      ADR_BC: rd_data = 32'({s_q.gr[RG_B], s_q.gr[RG_C]});
      ADR_DE: rd_data = 32'({s_q.gr[RG_D], s_q.gr[RG_E]});
      ADR_PTR: rd_data = 32'({s_q.gr[RG_H], s_q.gr[RG_L]});
      ADR_IDX_X: rd_data = 32'(s_q.idx_x);
      ADR_IDX_Y: rd_data = 32'(s_q.idx_y);
      ADR_SP: rd_data = 32'(s_q.sp);
      ADR_PC: rd_data = 32'(s_q.pc);
      default: rd_err = 1'b1;
    endcase
    // cpu registers only take writes while stopped and idle, so no instruction sees them move
    if (wr_en) begin
      unique case (wr_addr)
        ADR_CTRL: begin
          if (wr_strb[0]) s_d.run = wr_data[CTRL_RUN];
        end
        ADR_STATUS: begin
          if (wr_strb[0] && wr_data[ST_UNSUP]) s_d.unsup = 1'b0;
        end
        ADR_AF, ADR_BC, ADR_DE, ADR_PTR, ADR_IDX_X, ADR_IDX_Y, ADR_SP, ADR_PC: begin
          if (s_q.phase == PH_IDLE && !s_q.run) begin
            unique case (wr_addr)
              ADR_AF: {s_d.gr[RG_A], s_d.gr[RG_F]} =
                        put16({s_q.gr[RG_A], s_q.gr[RG_F]}, wr_data, wr_strb);
              ADR_BC: {s_d.gr[RG_B], s_d.gr[RG_C]} =
                        put16({s_q.gr[RG_B], s_q.gr[RG_C]}, wr_data, wr_strb);
              ADR_DE: {s_d.gr[RG_D], s_d.gr[RG_E]} =
                        put16({s_q.gr[RG_D], s_q.gr[RG_E]}, wr_data, wr_strb);
              ADR_PTR: {s_d.gr[RG_H], s_d.gr[RG_L]} =
                        put16({s_q.gr[RG_H], s_q.gr[RG_L]}, wr_data, wr_strb);
              ADR_IDX_X: s_d.idx_x = put16(s_q.idx_x, wr_data, wr_strb);
              ADR_IDX_Y: s_d.idx_y = put16(s_q.idx_y, wr_data, wr_strb);
              ADR_SP: s_d.sp = put16(s_q.sp, wr_data, wr_strb);
              default: s_d.pc = put16(s_q.pc, wr_data, wr_strb);
            endcase
          end
        end
        default: wr_err = 1'b1;
      endcase
    end
    if (s_q.tcnt != 3'h0) begin
      s_d.tcnt = s_q.tcnt - 3'h1;
    end else begin
      unique case (s_q.phase)
        PH_IDLE: begin
          s_d = next_instr(s_d);
        end
        PH_FETCH: begin
          s_d.op = mem_rdata;
          s_d.pc = pc1;
          if (mem_rdata == OP_CB) begin
            s_d = enter(s_d, PH_CBOP, T_M1, pc1, 1'b0, 8'h00);
          end else if (mem_rdata == OP_PFX_X || mem_rdata == OP_PFX_Y) begin
            s_d.pfx = (mem_rdata == OP_PFX_X) ? PFX_X : PFX_Y;
            s_d = enter(s_d, PH_PFX, T_M1, pc1, 1'b0, 8'h00);
          end else if (mem_rdata == OP_CALL) begin
            s_d.take = 1'b1;
            s_d = enter(s_d, PH_NLO, T_RD3, pc1, 1'b0, 8'h00);
          end else if (mem_rdata[GRP_LSB +: 2] == GRP_CALLCC &&
                       mem_rdata[2:0] == LOW_CALLCC) begin
            s_d.take = cond_ok(mem_rdata[CC_LSB +: 3], s_q.gr[RG_F]);
            s_d = enter(s_d, PH_NLO, T_RD3, pc1, 1'b0, 8'h00);
          end else begin
            if (mem_rdata == OP_CARRY_INV) begin
              s_d.gr[RG_F][FL_C] = !s_q.gr[RG_F][FL_C];
              s_d.gr[RG_F][FL_H] = s_q.gr[RG_F][FL_C];
              s_d.gr[RG_F][FL_N] = 1'b0;
            end else begin
              s_d.unsup = 1'b1;
            end
            fin = 1'b1;
            s_d = next_instr(s_d);
          end
        end
        PH_PFX: begin
          s_d.pc = pc1;
          if (mem_rdata == OP_CB) begin
            s_d = enter(s_d, PH_DISP, T_RD3, pc1, 1'b0, 8'h00);
          end else begin
            s_d.unsup = 1'b1;
            fin = 1'b1;
            s_d = next_instr(s_d);
          end
        end
        PH_DISP: begin
          idx = (s_q.pfx == PFX_X) ? s_q.idx_x : s_q.idx_y;
          s_d.pc = pc1;
          s_d.ea = idx + {{8{mem_rdata[7]}}, mem_rdata};
          s_d = enter(s_d, PH_XOP, T_RD5, pc1, 1'b0, 8'h00);
        end
        PH_XOP: begin
          s_d.op = mem_rdata;
          s_d.pc = pc1;
          if (mem_rdata[GRP_LSB +: 2] == GRP_BIT) begin
            s_d = enter(s_d, PH_MRD, T_RD4, s_q.ea, 1'b0, 8'h00);
          end else begin
            s_d.unsup = 1'b1;
            fin = 1'b1;
            s_d = next_instr(s_d);
          end
        end
        PH_CBOP: begin
          s_d.op = mem_rdata;
          s_d.pc = pc1;
          if (mem_rdata[GRP_LSB +: 2] != GRP_BIT) begin
            s_d.unsup = 1'b1;
            fin = 1'b1;
            s_d = next_instr(s_d);
          end else if (mem_rdata[RF_LSB +: 3] == RG_MEM) begin
            s_d = enter(s_d, PH_MRD, T_RD4, {s_q.gr[RG_H], s_q.gr[RG_L]},
                        1'b0, 8'h00);
          end else begin
            s_d = bit_test(s_d, s_q.gr[mem_rdata[RF_LSB +: 3]]);
            fin = 1'b1;
            s_d = next_instr(s_d);
          end
        end
        PH_MRD: begin
          s_d = bit_test(s_d, mem_rdata);
          fin = 1'b1;
          s_d = next_instr(s_d);
        end
        PH_NLO: begin
          s_d.lo = mem_rdata;
          s_d.pc = pc1;
          s_d = enter(s_d, PH_NHI, s_q.take ? T_RD4 : T_RD3, pc1, 1'b0, 8'h00);
        end
        PH_NHI: begin
          s_d.ea = {mem_rdata, s_q.lo};
          s_d.pc = pc1;
          if (s_q.take) begin
            s_d.sp = sp1;
            s_d = enter(s_d, PH_PUSHH, T_WR3, sp1, 1'b1, pc1[15:8]);
          end else begin
            fin = 1'b1;
            s_d = next_instr(s_d);
          end
        end
        PH_PUSHH: begin
          s_d.sp = sp1;
          s_d = enter(s_d, PH_PUSHL, T_WR3, sp1, 1'b1, s_q.pc[7:0]);
        end
        PH_PUSHL: begin
          s_d.pc = s_q.ea;
          fin = 1'b1;
          s_d = next_instr(s_d);
        end
        default: begin
          s_d.phase = PH_IDLE;
          s_d.mem = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [4:0] len_q, len_now;
  logic [15:0] ipc_q;
  logic start, sel_bit;
  assign start = s_q.phase == PH_FETCH && s_q.tcnt == T_M1 - 3'h1;
  assign len_now = start ? 5'h01 : len_q + 5'h01;
  assign sel_bit = mem_rdata[s_q.op[BS_LSB +: 3]];

  always_ff @(posedge clk) begin
    if (rst) begin
      len_q <= 5'h00;
      ipc_q <= 16'h0000;
    end else begin
      len_q <= len_now;
      if (start) ipc_q <= s_q.pc;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_MEM_BIT_LEN: assert property (fin && s_q.phase == PH_MRD && s_q.pfx == PFX_NONE
    |-> len_now == 5'h0C) else $error("memory bit test length wrong");
  AST_IDX_BIT_LEN: assert property (fin && s_q.phase == PH_MRD && s_q.pfx != PFX_NONE
    |-> len_now == 5'h14) else $error("indexed bit test length wrong");
  AST_REG_BIT_LEN: assert property (fin && s_q.phase == PH_CBOP
    && mem_rdata[GRP_LSB +: 2] == GRP_BIT
    |-> len_now == 5'h08) else $error("register bit test length wrong");
  AST_CALL_SKIP_LEN: assert property (fin && s_q.phase == PH_NHI
    |-> len_now == 5'h0A) else $error("skipped call length wrong");
  AST_CALL_TAKE_LEN: assert property (fin && s_q.phase == PH_PUSHL
    |-> len_now == 5'h11) else $error("taken call length wrong");
  AST_BIT_ZERO: assert property (s_q.phase == PH_MRD && s_q.tcnt == 3'h0
    |=> s_q.gr[RG_F][FL_Z] == !$past(sel_bit)) else $error("zero flag not inverse of bit");
  AST_BIT_FLAGS: assert property (s_q.phase == PH_MRD && s_q.tcnt == 3'h0
    |=> s_q.gr[RG_F][FL_H] && !s_q.gr[RG_F][FL_N] && $stable(s_q.gr[RG_F][FL_C]))
    else $error("bit test flags wrong");
  AST_BIT_NO_WRITE: assert property (s_q.phase == PH_MRD |-> !mem_o.wr && mem_o.rd)
    else $error("bit test wrote memory");
  AST_PUSH_ORDER: assert property (s_q.phase == PH_PUSHH && s_q.tcnt == 3'h0
    |=> s_q.phase == PH_PUSHL && mem_o.wr && mem_o.addr == $past(mem_o.addr) - 16'h1)
    else $error("push order wrong");
  AST_RET_ADDR: assert property (s_q.phase == PH_PUSHL && s_q.tcnt == 3'h0
    |-> {$past(mem_o.wdata, 3), mem_o.wdata} == ipc_q + 16'h3 && mem_o.addr == s_q.sp)
    else $error("pushed return address wrong");
  AST_CALL_FLAGS: assert property (s_q.phase inside {PH_NLO, PH_NHI, PH_PUSHH, PH_PUSHL}
    |=> $stable(s_q.gr[RG_F])) else $error("call changed flags");
  AST_CARRY_INV: assert property (fin && s_q.phase == PH_FETCH && mem_rdata == OP_CARRY_INV
    |-> len_now == 5'h04 ##1 s_q.gr[RG_F][FL_C] == !$past(s_q.gr[RG_F][FL_C])
    && s_q.gr[RG_F][FL_H] == $past(s_q.gr[RG_F][FL_C]) && !s_q.gr[RG_F][FL_N])
    else $error("carry invert wrong");

endmodule
`default_nettype wire

// *** verif/btcx_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module btcx_mem_model (
  input wire logic clk,
  input wire btcx_pkg::btcx_mem_t mem_i,
  output logic [7:0] rdata
);
  import btcx_pkg::*;
  // ---------------------------------------------
  // storage and write log
  // ---------------------------------------------
  logic [7:0] mem [0:65535];
  logic [15:0] wa_q [$];
  logic [7:0] wd_q [$];
  logic wr_q = 1'b0;
  logic [15:0] a_q = 16'h0000;
  // a bus not reading shows the inverted low address byte, so stale data is never mistaken for a read
  assign rdata = mem_i.rd ? mem[mem_i.addr] : ~mem_i.addr[7:0];
  always @(posedge clk) begin
    wr_q <= mem_i.wr;
    a_q <= mem_i.addr;
    if (mem_i.wr) begin
      mem[mem_i.addr] <= mem_i.wdata;
    end
    // one log entry per write cycle, even when two cycles run back to back
    if (mem_i.wr && (!wr_q || mem_i.addr != a_q)) begin
      wa_q.push_back(mem_i.addr);
      wd_q.push_back(mem_i.wdata);
    end
  end
endmodule
`default_nettype wire

// *** verif/bit_test_call_exec_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module bit_test_call_exec_tb;
  import btcx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  btcx_axi_req_t rq = '0;
  btcx_axi_rsp_t rs;
  btcx_mem_t mo;
  logic [7:0] md;
  logic [31:0] rv;
  logic [1:0] rr;
  int num_errors = 0;
  int checks_done = 0;
  int tcyc = 0;
  always #4 clk = ~clk;
  btcx_core dut_u (.clk(clk), .rst(rst), .axi_req(rq), .axi_rsp(rs), .mem_o(mo), .mem_rdata(md));
  btcx_mem_model mem_u (.clk(clk), .mem_i(mo), .rdata(md));
  // every clock with a bus cycle open is one T-state
  always @(posedge clk) begin
    if (mo.m1 | mo.rd | mo.wr) tcyc <= tcyc + 1;
  end
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // handshakes are judged on values settled before the edge, not racing its updates
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    do begin
      @(negedge clk);
      aw = rs.awready;
      w = rs.wready;
      b = rs.bvalid;
      @(posedge clk);
      if (aw) rq.awvalid <= 1'b0;
      if (w) rq.wvalid <= 1'b0;
    end while (!b);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, v;
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    do begin
      @(negedge clk);
      ar = rs.arready;
      v = rs.rvalid;
      rv = rs.rdata;
      rr = rs.rresp;
      @(posedge clk);
      if (ar) rq.arvalid <= 1'b0;
    end while (!v);
  endtask
  task automatic ld(input logic [31:0] b);
    for (int i = 0; i < 4; i++) begin
      mem_u.mem[16'h0100 + i] = b[31 - 8 * i -: 8];
    end
  endtask
  // run is dropped again at once, so exactly one instruction executes
  task automatic ex(input logic [15:0] pc, input int tx);
    wr(ADR_PC, {16'h0, pc});
    tcyc = 0;
    wr(ADR_CTRL, 32'h1);
    wr(ADR_CTRL, 32'h0);
    do rd(ADR_STATUS); while (rv[ST_BUSY] !== 1'b0);
    chk(tcyc, tx);
  endtask
  task automatic fz(input logic z);
    rd(ADR_AF);
    chk(rv & 32'hFF53, {16'h0, 8'h55, z ? 8'h51 : 8'h11});
  endtask
  task automatic cl(input logic [7:0] op, input logic tk, input logic [15:0] sp,
                    input logic [7:0] f);
    wr(ADR_AF, {16'h0, 8'h55, f});
    wr(ADR_SP, {16'h0, sp});
    mem_u.mem[16'h1A47] = op;
    mem_u.mem[16'h1A48] = 8'h35;
    mem_u.mem[16'h1A49] = 8'h21;
    mem_u.wa_q.delete();
    mem_u.wd_q.delete();
    ex(16'h1A47, tk ? 17 : 10);
    rd(ADR_PC);
    chk(rv, tk ? 32'h2135 : 32'h1A4A);
    rd(ADR_SP);
    chk(rv, {16'h0, tk ? sp - 16'h2 : sp});
    rd(ADR_AF);
    chk(rv, {16'h0, 8'h55, f});
    chk(mem_u.wa_q.size(), tk ? 2 : 0);
    if (tk) begin
      chk({mem_u.wa_q[0], mem_u.wd_q[0]}, {sp - 16'h1, 8'h1A});
      chk({mem_u.wa_q[1], mem_u.wd_q[1]}, {sp - 16'h2, 8'h4A});
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    #100us;
    num_errors++;
    print_verdict();
  end
  initial begin
    rq.bready <= 1'b1;
    rq.rready <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h40);
    chk({rr, rv[29:0]}, {RESP_SLVERR, 30'h0});
    wr(ADR_AF, 32'h5503);
    wr(ADR_BC, 32'h5555);
    wr(ADR_DE, 32'h5555);
    wr(ADR_PTR, 32'h5555);
    for (int r = 0; r < 8; r++) begin
      if (r == 6) continue;
      ld({OP_CB, GRP_BIT, r[2:0], r[2:0], 16'h0});
      ex(16'h0100, 8);
      fz(r[0]);
    end
    rd(ADR_BC);
    chk(rv, 32'h5555);
    wr(ADR_PTR, 32'h4444);
    mem_u.mem[16'h4444] = 8'h10;
    ld(32'hCB66_0000);
    ex(16'h0100, 12);
    fz(1'b0);
    rd(ADR_PTR);
    chk(rv, 32'h4444);
    wr(ADR_IDX_X, 32'h2000);
    wr(ADR_IDX_Y, 32'h2000);
    mem_u.mem[16'h1FFC] = 8'h40;
    mem_u.mem[16'h2004] = 8'hBF;
    ld(32'hDDCB_FC76);
    ex(16'h0100, 20);
    fz(1'b0);
    ld(32'hFDCB_0476);
    ex(16'h0100, 20);
    fz(1'b1);
    chk(mem_u.mem[16'h2004], 8'hBF);
    wr(ADR_AF, 32'h55C7);
    ld({OP_CARRY_INV, 24'h0});
    ex(16'h0100, 4);
    rd(ADR_AF);
    chk(rv, 32'h55D4);
    ex(16'h0100, 4);
    rd(ADR_AF);
    chk(rv, 32'h55C5);
    // flags all clear make even codes true; flags set make odd codes true
    for (int k = 0; k < 16; k++) begin
      cl({GRP_CALLCC, k[2:0], LOW_CALLCC}, ~(k[0] ^ k[3]), 16'h3002,
         k[3] ? 8'hC5 : 8'h00);
    end
    cl(OP_CALL, 1'b1, 16'h0001, 8'hC5);
    print_verdict();
  end
endmodule
`default_nettype wire
